// >>> core/mode_map_pkg.sv
/*
  Constants for the mode and resource mapping controller: register
  indices, field layouts, reset values, mode and resource codes.
  Assumes a 16-bit address space and a 32-bit register bus.
*/
package mode_map_pkg;
   // Register indices; byte address is four times the index
   localparam logic [7:0]  IDX_MODE        = 8'h0b;
   localparam logic [7:0]  IDX_RAMPOS      = 8'h10;
   localparam logic [7:0]  IDX_REGPOS      = 8'h11;
   localparam logic [7:0]  IDX_EEPOS       = 8'h12;
   localparam logic [7:0]  IDX_DBGCTL      = 8'h14;
   // Operating modes as {special_mode_select_low, mode_select_b, mode_select_a}
   localparam logic [2:0]  MODE_SSC        = 3'h0;
   localparam logic [2:0]  MODE_SEN        = 3'h1;
   localparam logic [2:0]  MODE_SPER       = 3'h2;
   localparam logic [2:0]  MODE_SEW        = 3'h3;
   localparam logic [2:0]  MODE_NEN        = 3'h5;
   localparam logic [2:0]  MODE_RSV        = 3'h6;
   localparam logic [1:0]  SEL_PERIPH      = 2'h2;
   // Resource select codes
   localparam logic [2:0]  RES_NONE        = 3'h0;
   localparam logic [2:0]  RES_DBGROM      = 3'h1;
   localparam logic [2:0]  RES_REG         = 3'h2;
   localparam logic [2:0]  RES_RAM         = 3'h3;
   localparam logic [2:0]  RES_EE          = 3'h4;
   localparam logic [2:0]  RES_ROM         = 3'h5;
   localparam logic [2:0]  RES_EXT         = 3'h6;
   // Reset positions and fixed offsets
   localparam logic [4:0]  REGPOS_RST      = 5'h00;
   localparam logic [4:0]  RAMPOS_RST      = 5'h01;
   localparam logic [3:0]  EEPOS_RST       = 4'h0;
   localparam logic [11:0] EE_START        = 12'hd00;
   localparam logic [7:0]  DBG_PAGE        = 8'hff;
   localparam logic [8:0]  PORT_E_DATA_DATA_OFS  = 9'h008;
   localparam logic [8:0]  PORT_E_DATA_DIR_OFS   = 9'h009;
   localparam logic [8:0]  MODE_OFS        = 9'h00b;
   // Cycles of bus quiet before wait-mode shutdown
   localparam logic [3:0]  WAIT_SD_CYC     = 4'h4;
   localparam logic [1:0]  RESP_OKAY       = 2'h0;
   localparam logic [1:0]  RESP_SLVERR     = 2'h2;
   typedef enum logic [1:0] {X_IDLE, X_HIGH, X_LOW} ext_state_t;
endpackage

// >>> core/mode_and_resource_map_control.sv
/*
  Mode control and internal resource address decode with an AXI4-Lite
  register slave. Assumes one clock, synchronous active-high reset and
  mode pins that are stable while reset is held.
*/
//////////////////////////////////////////////////////////////////////
// Behaviour
// R01: Latch background and mode pins at reset release
// R02: Special wide mode drives port E bus control
// R03: Narrow mode splits transfers high byte first
// R04: Special single-chip skips vector, debug active
// R05: Peripheral mode halts CPU, left only by reset
// R06: Enabled debug activates by command or instruction
// R07: Active debug maps debug ROM at top page
// R08: Debug accesses use idle bus cycles
// R09: Mapping registers written once in normal modes
// R10: Mapping writes take effect two cycles later
// R11: Decode priority debug, reg, RAM, EEPROM, ROM, external
// R12: Unclaimed addresses go external in expanded modes
// R13: Mode register unmapped in peripheral mode
// R14: Mode bits read back the latched mode
// R15: Special-mode bit writable when zero, first ignored
// R16: Mode select once or anytime, peripheral rejected
// R17: Stretch enable forced in expanded, write rules
// R18: Internal visibility shows internal cycles on bus
// R19: Visibility and emulation write once or after first
// R20: Wait-mode bus shutdown after quiet delay
// R21: Port E emulation unmaps port E registers
// R22: Register block 512 bytes on 2K boundary
// R23: Block position write once normal, anytime special
// R24: Position bits form address bits 15 to 11
// R25: Sticky written flags cleared only by reset
`timescale 1ns/1ps
`default_nettype none
module mode_and_resource_map_control #(
   parameter int ADDR_W = 12
) (
   input  wire logic              mclk,
   input  wire logic              rst,
   input  wire logic              backgroundPin,
   input  wire logic              modeBPin,
   input  wire logic              modeAPin,
   input  wire logic [ADDR_W-1:0] awaddr,
   input  wire logic              awvalid,
   output var  logic              awready,
   input  wire logic [31:0]       wdata,
   input  wire logic [3:0]        wstrb,
   input  wire logic              wvalid,
   output var  logic              wready,
   output var  logic [1:0]        bresp,
   output var  logic              bvalid,
   input  wire logic              bready,
   input  wire logic [ADDR_W-1:0] araddr,
   input  wire logic              arvalid,
   output var  logic              arready,
   output var  logic [31:0]       rdata,
   output var  logic [1:0]        rresp,
   output var  logic              rvalid,
   input  wire logic              rready,
   input  wire logic [15:0]       cpuAddr,
   input  wire logic              cpuAddrValid,
   input  wire logic              cpuBusBusy,
   input  wire logic              debugCmdActivate,
   input  wire logic              debugHaltInstr,
   input  wire logic              debugExit,
   input  wire logic              debugAccReq,
   input  wire logic              extReq,
   input  wire logic              waitMode,
   output var  logic [2:0]        resourceSel,
   output var  logic              debugActive,
   output var  logic              debugAccGrant,
   output var  logic              cpuActive,
   output var  logic              skipResetVector,
   output var  logic              portEBusCtrl,
   output var  logic              eStretch,
   output var  logic              visibleInternal,
   output var  logic              visibleWide,
   output var  logic              extCycle,
   output var  logic              extHighByte,
   output var  logic              extDone,
   output var  logic              busShutdown
);
   typedef enum logic [1:0] {X_IDLE, X_HIGH, X_LOW} ext_state_t;
   typedef struct packed {
      logic [2:0]  mode;
      logic        e_clock_stretch_enable;
      logic        internal_visibility;
      logic        ext_bus_wait_shutdown;
      logic        port_e_emulation;
      logic        modeFirst;
      logic        selWr;
      logic        estrWr;
      logic        visWr;
      logic [4:0]  regPos;
      logic [4:0]  regEff;
      logic        regWr;
      logic [4:0]  ramPos;
      logic [4:0]  ramEff;
      logic        ramWr;
      logic [3:0]  eePos;
      logic [3:0]  eeEff;
      logic        eeWr;
      logic        dbgEn;
      logic        dbgAct;
      logic        awHeld;
      logic [ADDR_W-1:0] awAddr;
      logic        wHeld;
      logic [7:0]  wByte;
      logic        wLane0;
      logic        awRdy;
      logic        wRdy;
      logic        bvalid;
      logic [1:0]  bresp;
      logic        arRdy;
      logic        rvalid;
      logic [31:0] rdata;
      logic [1:0]  rresp;
      logic [2:0]  sel;
      logic        grant;
      logic        cpuAct;
      logic        skip;
      logic        peCtrl;
      logic        vis;
      logic        visWide;
      ext_state_t  xst;
      logic        extCycle;
      logic        extHigh;
      logic        extDone;
      logic [3:0]  waitCnt;
      logic        shut;
   } state_t;

   state_t      s;
   state_t      n;
   logic        special;
   logic        expanded;
   logic        single;
   logic        periph;
   logic        narrow;
   logic        wrGo;
   logic [7:0]  wIdx;
   logic [7:0]  rIdx;
   logic        wMap;
   logic        rMap;
   logic [7:0]  wd;
   logic        regHit;

   //////////////////////////////////////////////////////////////////
   // Mapped register index check, mode register absent in peripheral
   function automatic logic mapped(input logic [ADDR_W-1:0] a, input logic per);
      logic [7:0] i;
      i = a[9:2];
      // R13 mode register unmapped
      mapped = (a[ADDR_W-1:10] == '0) && (a[1:0] == 2'h0) &&
               ((i == mode_map_pkg::IDX_MODE && !per) ||
                i == mode_map_pkg::IDX_RAMPOS || i == mode_map_pkg::IDX_REGPOS ||
                i == mode_map_pkg::IDX_EEPOS || i == mode_map_pkg::IDX_DBGCTL);
   endfunction

   //////////////////////////////////////////////////////////////////
   // Mode qualifiers from the current mode bits
   always_comb
   begin
      special  = !s.mode[2];
      periph   = s.mode == mode_map_pkg::MODE_SPER;
      expanded = s.mode[0];
      single   = !s.mode[0] && !periph;
      narrow   = s.mode[1:0] == 2'h1;
      wIdx     = s.awAddr[9:2];
      rIdx     = araddr[9:2];
      wd       = s.wByte;
      wrGo     = s.awHeld && s.wHeld && !s.bvalid;
      wMap     = mapped(s.awAddr, periph);
      rMap     = mapped(araddr, periph);
      // R21 emulated port E registers leave the block
      // R22 block is the first 512 bytes of a 2K page
      // R24 position bits compare with address 15 to 11
      regHit   = cpuAddr[15:11] == s.regEff && cpuAddr[10:9] == 2'h0 &&
                 !(s.port_e_emulation && expanded &&
                   (cpuAddr[8:0] == mode_map_pkg::PORT_E_DATA_DATA_OFS ||
                    cpuAddr[8:0] == mode_map_pkg::PORT_E_DATA_DIR_OFS)) &&
                 !(periph && cpuAddr[8:0] == mode_map_pkg::MODE_OFS);
   end

   //////////////////////////////////////////////////////////////////
   // Next state: bus slave, register writes, decode, sequencers
   always_comb
   begin
      n = s;
      n.extDone = 1'b0;
      n.grant   = 1'b0;
      // Address and data channels captured in either order
      if (awvalid && s.awRdy)
      begin
         n.awHeld = 1'b1;
         n.awAddr = awaddr;
      end
      if (wvalid && s.wRdy)
      begin
         n.wHeld  = 1'b1;
         n.wByte  = wdata[7:0];
         n.wLane0 = wstrb[0];
      end
      if (bready && s.bvalid)
         n.bvalid = 1'b0;
      if (wrGo)
      begin
         n.awHeld = 1'b0;
         n.wHeld  = 1'b0;
         n.bvalid = 1'b1;
         n.bresp  = wMap ? mode_map_pkg::RESP_OKAY : mode_map_pkg::RESP_SLVERR;
         if (wMap && s.wLane0)
         begin
            unique case (wIdx)
               mode_map_pkg::IDX_MODE:
               begin
                  // R15 special bit only from zero, first write dropped
                  if (special && s.modeFirst)
                     n.mode[2] = wd[7];
                  // R16 select once in normal, never peripheral
                  // R25 sticky written flag
                  if ((special || !s.selWr) && wd[6:5] != mode_map_pkg::SEL_PERIPH)
                  begin
                     n.mode[1:0] = wd[6:5];
                     n.selWr     = 1'b1;
                  end
                  // R17 stretch write once normal, anytime special
                  if (special || !s.estrWr)
                  begin
                     n.e_clock_stretch_enable   = wd[4];
                     n.estrWr = 1'b1;
                  end
                  // R19 visibility and emulation write rules
                  if (special ? s.modeFirst : !s.visWr)
                  begin
                     n.internal_visibility  = wd[3];
                     n.port_e_emulation   = wd[0];
                     n.visWr = 1'b1;
                  end
                  // R20 shutdown bit writable only in normal modes
                  if (!special)
                     n.ext_bus_wait_shutdown = wd[1];
                  n.modeFirst = 1'b1;
               end
               mode_map_pkg::IDX_REGPOS:
                  // R23 block position write once in normal modes
                  // R09 single write in normal modes
                  if (special || !s.regWr)
                  begin
                     n.regPos = wd[7:3];
                     n.regWr  = 1'b1;
                  end
               mode_map_pkg::IDX_RAMPOS:
                  if (special || !s.ramWr)
                  begin
                     n.ramPos = wd[7:3];
                     n.ramWr  = 1'b1;
                  end
               mode_map_pkg::IDX_EEPOS:
                  if (special || !s.eeWr)
                  begin
                     n.eePos = wd[7:4];
                     n.eeWr  = 1'b1;
                  end
               default:
                  n.dbgEn = wd[0];
            endcase
         end
      end
      // R17 stretch forced in expanded modes
      if (n.mode[0])
         n.e_clock_stretch_enable = 1'b1;
      // Read channel, one cycle to the answer
      if (rready && s.rvalid)
         n.rvalid = 1'b0;
      if (arvalid && s.arRdy)
      begin
         n.rvalid = 1'b1;
         n.rresp  = rMap ? mode_map_pkg::RESP_OKAY : mode_map_pkg::RESP_SLVERR;
         n.rdata  = 32'h0;
         if (rMap)
         begin
            unique case (rIdx)
               // R14 mode bits read the latched mode
               mode_map_pkg::IDX_MODE:
                  n.rdata[7:0] = {s.mode, s.e_clock_stretch_enable, s.internal_visibility, 1'b0, s.ext_bus_wait_shutdown, s.port_e_emulation};
               mode_map_pkg::IDX_REGPOS:
                  n.rdata[7:0] = {s.regPos, 3'h0};
               mode_map_pkg::IDX_RAMPOS:
                  n.rdata[7:0] = {s.ramPos, 3'h0};
               mode_map_pkg::IDX_EEPOS:
                  n.rdata[7:0] = {s.eePos, 4'h1};
               default:
                  n.rdata[7:0] = {6'h0, s.dbgAct, s.dbgEn};
            endcase
         end
      end
      n.awRdy = !n.awHeld && !n.bvalid;
      n.wRdy  = !n.wHeld && !n.bvalid;
      n.arRdy = !n.rvalid;
      // R10 mapping takes effect one cycle after the stored write
      n.regEff = s.regPos;
      n.ramEff = s.ramPos;
      n.eeEff  = s.eePos;
      // R06 activation by command or halt instruction
      if (s.dbgEn && !periph && (debugCmdActivate || debugHaltInstr))
         n.dbgAct = 1'b1;
      else if (debugExit)
         n.dbgAct = 1'b0;
      // R08 debug access granted on an idle bus cycle
      n.grant = debugAccReq && !cpuBusBusy && !s.grant;
      // R11 fixed decode precedence
      // R07 debug ROM over the top page
      // R12 unclaimed space is external when expanded
      if (!cpuAddrValid)
         n.sel = mode_map_pkg::RES_NONE;
      else if (s.dbgAct && cpuAddr[15:8] == mode_map_pkg::DBG_PAGE)
         n.sel = mode_map_pkg::RES_DBGROM;
      else if (regHit)
         n.sel = mode_map_pkg::RES_REG;
      else if (cpuAddr[15:11] == s.ramEff && !cpuAddr[10])
         n.sel = mode_map_pkg::RES_RAM;
      else if (cpuAddr[15:12] == s.eeEff && cpuAddr[11:0] >= mode_map_pkg::EE_START)
         n.sel = mode_map_pkg::RES_EE;
      else if (single && cpuAddr[15])
         n.sel = mode_map_pkg::RES_ROM;
      else if (expanded)
         n.sel = mode_map_pkg::RES_EXT;
      else
         n.sel = mode_map_pkg::RES_NONE;
      // R05 CPU idle in peripheral mode
      n.cpuAct  = !periph;
      // R04 no vector fetch in special single-chip
      n.skip    = s.mode == mode_map_pkg::MODE_SSC;
      // R02 port E pins in bus-control role
      n.peCtrl  = s.mode == mode_map_pkg::MODE_SEW || (expanded && !s.port_e_emulation);
      // R18 visibility, wide format in special narrow
      n.vis     = s.internal_visibility && expanded && s.mode != mode_map_pkg::MODE_NEN;
      n.visWide = n.vis && s.mode == mode_map_pkg::MODE_SEN;
      // R03 external transfer sequencer
      unique case (s.xst)
         X_IDLE:
            if (extReq && expanded)
            begin
               n.extCycle = 1'b1;
               n.extHigh  = narrow;
               n.xst      = narrow ? X_HIGH : X_LOW;
            end
         X_HIGH:
         begin
            n.extHigh = 1'b0;
            n.xst     = X_LOW;
         end
         X_LOW:
         begin
            n.extCycle = 1'b0;
            n.extDone  = 1'b1;
            n.xst      = X_IDLE;
         end
      endcase
      // R20 shutdown after the bus has been quiet for a while
      if (s.ext_bus_wait_shutdown && waitMode)
      begin
         if (!cpuBusBusy && s.xst == X_IDLE && s.waitCnt != mode_map_pkg::WAIT_SD_CYC)
            n.waitCnt = s.waitCnt + 4'h1;
      end
      else
         n.waitCnt = 4'h0;
      n.shut = s.ext_bus_wait_shutdown && waitMode && s.waitCnt == mode_map_pkg::WAIT_SD_CYC;
      // R01 pins latched each reset cycle, last one holds
      if (rst)
      begin
         n = '0;
         n.mode = {backgroundPin, modeBPin, modeAPin};
         if (n.mode == mode_map_pkg::MODE_RSV)
            n.mode = mode_map_pkg::MODE_SPER;
         n.e_clock_stretch_enable   = 1'b1;
         n.regPos = mode_map_pkg::REGPOS_RST;
         n.regEff = mode_map_pkg::REGPOS_RST;
         n.ramPos = mode_map_pkg::RAMPOS_RST;
         n.ramEff = mode_map_pkg::RAMPOS_RST;
         n.eePos  = mode_map_pkg::EEPOS_RST;
         n.eeEff  = mode_map_pkg::EEPOS_RST;
         n.xst    = X_IDLE;
         // R04 debug enabled and active out of reset only in special single-chip mode
         n.dbgEn  = n.mode == mode_map_pkg::MODE_SSC;
         n.dbgAct = n.dbgEn;
      end
   end

   // State register
   always_ff @(posedge mclk)
      s <= n;

   // Outputs straight from the state register
   assign awready         = s.awRdy;
   assign wready          = s.wRdy;
   assign bvalid          = s.bvalid;
   assign bresp           = s.bresp;
   assign arready         = s.arRdy;
   assign rvalid          = s.rvalid;
   assign rdata           = s.rdata;
   assign rresp           = s.rresp;
   assign resourceSel     = s.sel;
   assign debugActive     = s.dbgAct;
   assign debugAccGrant   = s.grant;
   assign cpuActive       = s.cpuAct;
   assign skipResetVector = s.skip;
   assign portEBusCtrl    = s.peCtrl;
   assign eStretch        = s.e_clock_stretch_enable;
   assign visibleInternal = s.vis;
   assign visibleWide     = s.visWide;
   assign extCycle        = s.extCycle;
   assign extHighByte     = s.extHigh;
   assign extDone         = s.extDone;
   assign busShutdown     = s.shut;

   //////////////////////////////////////////////////////////////////
   // Checks
   default clocking cb @(posedge mclk); endclocking
   default disable iff (rst);

   // R01 latched mode matches pins
   property p_latch;
      $past(rst) && $past({backgroundPin, modeBPin, modeAPin}) != mode_map_pkg::MODE_RSV
         |-> s.mode == $past({backgroundPin, modeBPin, modeAPin});
   endproperty
   a_latch: assert property (p_latch) else $error("mode not latched"); // R01

   // R04 vector skip follows mode
   property p_skip;
      !$past(rst) |-> skipResetVector == ($past(s.mode) == mode_map_pkg::MODE_SSC);
   endproperty
   a_skip: assert property (p_skip) else $error("skip mismatch"); // R04

   // R05 CPU idle in peripheral mode
   property p_cpu;
      !$past(rst) && $past(s.mode) == mode_map_pkg::MODE_SPER |-> !cpuActive;
   endproperty
   a_cpu: assert property (p_cpu) else $error("cpu active in peripheral"); // R05

   // R16 peripheral select never written
   property p_sel;
      !$past(rst) && $changed(s.mode[1:0]) |-> s.mode[1:0] != mode_map_pkg::SEL_PERIPH;
   endproperty
   a_sel: assert property (p_sel) else $error("peripheral selected by write"); // R16

   // R07 debug ROM claims the top page
   property p_dbg;
      cpuAddrValid && s.dbgAct && cpuAddr[15:8] == mode_map_pkg::DBG_PAGE
         |=> resourceSel == mode_map_pkg::RES_DBGROM;
   endproperty
   a_dbg: assert property (p_dbg) else $error("debug ROM not decoded"); // R07

   // R10 new position used one cycle after it is stored
   property p_eff;
      $changed(s.regPos) |=> s.regEff == $past(s.regPos);
   endproperty
   a_eff: assert property (p_eff) else $error("mapping delay wrong"); // R10

   // R09 locked position holds in normal modes
   property p_once;
      s.mode[2] && s.regWr |=> $stable(s.regPos);
   endproperty
   a_once: assert property (p_once) else $error("second write taken"); // R09

   // R03 narrow transfer high byte then low byte
   property p_split;
      s.xst == X_IDLE && extReq && expanded && narrow
         |=> extCycle && extHighByte ##1 extCycle && !extHighByte ##1 extDone;
   endproperty
   a_split: assert property (p_split) else $error("byte split wrong"); // R03

   // R17 stretch held in expanded modes
   property p_e_clock_stretch_enable;
      s.mode[0] |-> eStretch;
   endproperty
   a_e_clock_stretch_enable: assert property (p_e_clock_stretch_enable) else $error("stretch not forced"); // R17
endmodule
`default_nettype wire

// >>> testbench/ext_bus_host_model.sv
/*
  Far-side model: serial debug host and external bus observer.
  Assumes the block's clock; counts byte beats of each transfer.
*/
`timescale 1ns/1ps
`default_nettype none
module ext_bus_host_model (
   input  wire logic mclk,
   input  wire logic cmdGo,
   input  wire logic extCycle,
   input  wire logic extHighByte,
   input  wire logic extDone,
   output var  logic debugCmdActivate,
   output var  int   hiCnt,
   output var  int   loCnt,
   output var  int   doneCnt
);
   logic hiSeen = 1'b0;
   always_ff @(posedge mclk)
      debugCmdActivate <= cmdGo;
   always_ff @(posedge mclk)
   begin
      if (extCycle && extHighByte)
      begin
         hiCnt  <= hiCnt + 1;
         hiSeen <= 1'b1;
      end
      if (extCycle && !extHighByte && hiSeen)
         loCnt <= loCnt + 1;
      if (extDone)
         doneCnt <= doneCnt + 1;
   end
endmodule
`default_nettype wire

// >>> testbench/mode_and_resource_map_control_tb.sv
/*
  Self-checking bench for the mode and mapping controller.
  Assumes the package is compiled first and the model beside it.
*/
`timescale 1ns/1ps
`default_nettype none
module mode_and_resource_map_control_tb;
   logic        mclk, rst, backgroundPin, modeBPin, modeAPin;
   logic [11:0] awaddr, araddr;
   logic [31:0] wdata, rdata, rd;
   logic [3:0]  wstrb;
   logic        awvalid, awready, wvalid, wready, bvalid, bready;
   logic        arvalid, arready, rvalid, rready, eStretch, portEBusCtrl, debugAccGrant;
   logic [1:0]  bresp, rresp, rs;
   logic [15:0] cpuAddr;
   logic        cpuAddrValid, extReq, cmdGo, debugCmdActivate;
   logic        cpuBusBusy, debugHaltInstr, debugExit, debugAccReq, waitMode, busShutdown;
   logic [2:0]  resourceSel;
   logic        debugActive, cpuActive, skipResetVector, extCycle, extHighByte, extDone;
   int          hiCnt, loCnt, doneCnt, n_mismatch, tests_run;

   mode_and_resource_map_control DUT (.mclk(mclk), .rst(rst),
      .backgroundPin(backgroundPin), .modeBPin(modeBPin), .modeAPin(modeAPin),
      .awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata),
      .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
      .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
      .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
      .rready(rready), .cpuAddr(cpuAddr), .cpuAddrValid(cpuAddrValid),
      .cpuBusBusy(cpuBusBusy), .debugCmdActivate(debugCmdActivate),
      .debugHaltInstr(debugHaltInstr), .debugExit(debugExit), .debugAccReq(debugAccReq),
      .extReq(extReq), .waitMode(waitMode), .resourceSel(resourceSel),
      .debugActive(debugActive), .debugAccGrant(debugAccGrant), .cpuActive(cpuActive),
      .skipResetVector(skipResetVector), .portEBusCtrl(portEBusCtrl),
      .eStretch(eStretch), .visibleInternal(), .visibleWide(), .extCycle(extCycle),
      .extHighByte(extHighByte), .extDone(extDone), .busShutdown(busShutdown));

   ext_bus_host_model host (.mclk(mclk), .cmdGo(cmdGo), .extCycle(extCycle),
      .extHighByte(extHighByte), .extDone(extDone),
      .debugCmdActivate(debugCmdActivate), .hiCnt(hiCnt), .loCnt(loCnt),
      .doneCnt(doneCnt));

   ////////////////////////////////////////
   // Compare and count
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
      tests_run++;
      if (s !== e)
      begin
         n_mismatch++;
         $display("ERROR %s expected %h seen %h", nm, e, s);
      end
   endtask

   // Register bus write, response left in rs
   task automatic axw(input logic [11:0] a, input logic [31:0] d);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      do
      begin
         @(posedge mclk);
         if (awready) awvalid <= 1'b0;
         if (wready) wvalid <= 1'b0;
      end while (!bvalid);
      rs = bresp;
      bready <= 1'b0;
      @(posedge mclk);
   endtask

   // Register bus read, data in rd
   task automatic axr(input logic [11:0] a);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do
      begin
         @(posedge mclk);
         if (arready) arvalid <= 1'b0;
      end while (!rvalid);
      rd = rdata;
      rs = rresp;
      rready <= 1'b0;
      @(posedge mclk);
   endtask

   // Decode one address
   task automatic dec(input logic [15:0] a, input logic [2:0] e);
      cpuAddr <= a;
      cpuAddrValid <= 1'b1;
      repeat (2) @(posedge mclk);
      chk("resourceSel", {29'h0, e}, {29'h0, resourceSel});
   endtask

   task automatic rst_to(input logic [2:0] m);
      rst <= 1'b1;
      {backgroundPin, modeBPin, modeAPin} <= m;
      repeat (16) @(posedge mclk);
      rst <= 1'b0;
      repeat (2) @(posedge mclk);
   endtask

   task automatic pulse(input int k);
      {debugExit, debugHaltInstr, cmdGo, extReq} <= 4'h1 << k;
      @(posedge mclk);
      {debugExit, debugHaltInstr, cmdGo, extReq} <= 4'h0;
      repeat (4) @(posedge mclk);
   endtask

   ////////////////////////////////////////
   // Normal expanded narrow: readback and relocation
   task automatic t_normal_map;
      rst_to(3'h5);
      axr(12'h02c);
      chk("mode", 32'h5, {29'h0, rd[7:5]});
      chk("stretch bit", 32'h1, {31'h0, rd[4]});
      chk("eStretch", 32'h1, {31'h0, eStretch});
      axr(12'h044);
      chk("regpos reset", 32'h0, rd);
      dec(16'h01ff, mode_map_pkg::RES_REG);
      dec(16'h0800, mode_map_pkg::RES_RAM);
      dec(16'h4000, mode_map_pkg::RES_EXT);
      axw(12'h044, 32'h08);
      chk("regpos resp", {30'h0, mode_map_pkg::RESP_OKAY}, {30'h0, rs});
      repeat (4) @(posedge mclk);
      dec(16'h0800, mode_map_pkg::RES_REG);
      dec(16'h0a00, mode_map_pkg::RES_RAM);
      axw(12'h044, 32'h10);
      axr(12'h044);
      chk("regpos once", 32'h08, rd);
      axr(12'h3fc);
      chk("unmapped", {30'h0, mode_map_pkg::RESP_SLVERR}, {30'h0, rs});
   endtask

   task automatic t_ext_narrow;
      pulse(0);
      chk("high beats", 32'h1, hiCnt);
      chk("low beats", 32'h1, loCnt);
      chk("done", 32'h1, doneCnt);
   endtask

   task automatic t_debug;
      pulse(1);
      chk("debug off", 32'h0, {31'h0, debugActive});
      axw(12'h050, 32'h1);
      pulse(1);
      chk("debug on", 32'h1, {31'h0, debugActive});
      dec(16'hff00, mode_map_pkg::RES_DBGROM);
      dec(16'hfeff, mode_map_pkg::RES_EXT);
      pulse(3);
      chk("debug exit", 32'h0, {31'h0, debugActive});
      pulse(2);
      chk("halt instr", 32'h1, {31'h0, debugActive});
      {debugAccReq, cpuBusBusy} <= 2'h3;
      repeat (2) @(posedge mclk);
      chk("grant busy", 32'h0, {31'h0, debugAccGrant});
      cpuBusBusy <= 1'b0;
      repeat (2) @(posedge mclk);
      chk("grant", 32'h1, {31'h0, debugAccGrant});
      debugAccReq <= 1'b0;
      axw(12'h02c, 32'h22);
      waitMode <= 1'b1;
      repeat (6) @(posedge mclk);
      chk("shutdown", 32'h1, {31'h0, busShutdown});
      waitMode <= 1'b0;
   endtask

   task automatic t_special;
      rst_to(3'h0);
      chk("debug", 32'h1, {31'h0, debugActive});
      chk("skip", 32'h1, {31'h0, skipResetVector});
      dec(16'hfffe, mode_map_pkg::RES_DBGROM);
      axw(12'h02c, 32'h40);
      axr(12'h02c);
      chk("mode kept", 32'h0, {29'h0, rd[7:5]});
      pulse(0);
      chk("no ext bus", 32'h1, hiCnt);
   endtask

   task automatic t_periph;
      rst_to(3'h3);
      chk("port E role", 32'h1, {31'h0, portEBusCtrl});
      rst_to(3'h6);
      chk("cpu off", 32'h0, {31'h0, cpuActive});
      axr(12'h02c);
      chk("mode gone", {30'h0, mode_map_pkg::RESP_SLVERR}, {30'h0, rs});
   endtask

   task automatic report_and_stop;
      $display("Comparisons %0d mismatches %0d", tests_run, n_mismatch);
      if (n_mismatch == 0 && tests_run > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask

   ////////////////////////////////////////
   // Clock
   initial
   begin
      mclk = 1'b0;
      forever #50 mclk = ~mclk;
   end

   // Watchdog
   initial
   begin
      repeat (20000) @(posedge mclk);
      n_mismatch++;
      report_and_stop();
   end

   // Main sequence
   initial
   begin
      {rst, backgroundPin, modeBPin, modeAPin} = 4'hf;
      {awvalid, wvalid, bready, arvalid, rready} = 5'h0;
      {cpuAddrValid, extReq, cmdGo} = 3'h0;
      {cpuBusBusy, debugHaltInstr, debugExit, debugAccReq, waitMode} = 5'h0;
      awaddr = 12'h0;
      araddr = 12'h0;
      wdata = 32'h0;
      wstrb = 4'h1;
      cpuAddr = 16'h0;
      @(posedge mclk);
      t_normal_map();
      t_ext_narrow();
      t_debug();
      t_special();
      t_periph();
      report_and_stop();
   end
endmodule
`default_nettype wire
